// ==== core/calib_pkg.sv ====
// constants, register map and types for the measurement calibration datapath
package calib_pkg;
   localparam int NCELL   = 14;
   localparam int NGAIN   = 18;
   localparam int NTEMP   = 10;
   localparam int GAIN_W  = 16;
   localparam int OFS_W   = 16;
   localparam int CNT_W   = 16;
   localparam int FRAC_SH = 16;
   localparam int ADDR_W  = 12;
   localparam int SAMP_W  = 8;

   // gain slots after the cells
   localparam int GAIN_STACK = 14;
   localparam int GAIN_PACK  = 15;
   localparam int GAIN_LOAD  = 16;
   localparam int GAIN_ADC  = 17;

   // register map, byte addresses
   localparam logic [11:0] CTRL_ADDR  = 12'h000;
   localparam logic [11:0] STAT_ADDR  = 12'h004;
   localparam logic [11:0] CMD_ADDR   = 12'h008;
   localparam logic [11:0] RESP_ADDR  = 12'h00c;
   localparam logic [11:0] CELLO_ADDR = 12'h010;
   localparam logic [11:0] DIVO_ADDR  = 12'h014;
   localparam logic [11:0] CCO_ADDR   = 12'h018;
   localparam logic [11:0] CCS_ADDR   = 12'h01c;
   localparam logic [11:0] CCG_ADDR   = 12'h020;
   localparam logic [11:0] CAPG_ADDR  = 12'h024;
   localparam logic [11:0] OVO_ADDR   = 12'h028;
   localparam logic [11:0] UVO_ADDR   = 12'h02c;
   localparam logic [11:0] GAIN_BASE  = 12'h040;
   localparam logic [11:0] TEMP_BASE  = 12'h0a0;

   localparam int CTRL_FULL_BIT = 0;
   localparam int CTRL_CFG_BIT  = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;

   localparam logic [15:0] CMD_OV_CAL = 16'h0001;
   localparam logic [15:0] CMD_UV_CAL = 16'h0002;

   localparam logic [15:0] NOM_CELL_GAIN = 16'h2f58;
   localparam logic [15:0] NOM_ADC_GAIN  = 16'h0fc8;
   localparam logic [15:0] NOM_DIV_GAIN  = 16'h2f58;

   localparam logic [7:0]  FP_POINT    = 8'h96;
   localparam logic [31:0] CAP_K       = 32'h4891a2b4;
   localparam logic [31:0] CUR_GAIN_RST = 32'h3f800000;
   localparam logic [7:0]  CC_SAMP_RST = 8'h01;

   localparam int CLK_NS     = 100;
   localparam int SETTLE_NS  = 10000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      K_CELL  = 3'b000,
      K_STACK = 3'b001,
      K_PACK  = 3'b010,
      K_LOAD  = 3'b011,
      K_GPIN  = 3'b100,
      K_CURR  = 3'b101,
      K_TEMP  = 3'b110
   } kind_t;

   typedef enum logic {
      CAL_IDLE   = 1'b0,
      CAL_SEARCH = 1'b1
   } cal_state_t;
endpackage : calib_pkg

// ==== core/fp_mul.sv ====
// single precision float multiplier, truncating, no subnormals
`timescale 1ns/100ps
module fp_mul #(
   parameter int EXP_W = 8,
   parameter int MAN_W = 23
) (
   input  wire logic [EXP_W+MAN_W:0] a,
   input  wire logic [EXP_W+MAN_W:0] b,
   output logic      [EXP_W+MAN_W:0] p
);
   localparam int TOP = EXP_W + MAN_W;
   localparam logic signed [EXP_W+1:0] BIAS = (EXP_W+2)'(2 ** (EXP_W - 1) - 1);
   localparam logic signed [EXP_W+1:0] EMAX = (EXP_W+2)'(2 ** EXP_W - 1);

   if (EXP_W < 2 || MAN_W < 1) begin : g_chk
      $error("fp_mul: unsupported widths");
   end

   logic [2*MAN_W+1:0]      mp;
   logic signed [EXP_W+1:0] ex;
   logic                    norm;
   logic                    sgn;

   always_comb begin
      mp   = {1'b1, a[MAN_W-1:0]} * {1'b1, b[MAN_W-1:0]};
      norm = mp[2*MAN_W+1];
      sgn  = a[TOP] ^ b[TOP];
      ex   = $signed({2'b00, a[TOP-1:MAN_W]}) + $signed({2'b00, b[TOP-1:MAN_W]})
             - BIAS + $signed({{(EXP_W+1){1'b0}}, norm});
      if (a[TOP-1:MAN_W] == '0 || b[TOP-1:MAN_W] == '0 || ex <= 0) begin
         p = {sgn, {(TOP){1'b0}}};
      end else if (ex >= EMAX) begin
         p = {sgn, {(EXP_W){1'b1}}, {(MAN_W){1'b0}}};
      end else if (norm) begin
         p = {sgn, ex[EXP_W-1:0], mp[2*MAN_W:MAN_W+1]};
      end else begin
         p = {sgn, ex[EXP_W-1:0], mp[2*MAN_W-1:MAN_W]};
      end
   end
endmodule : fp_mul

// ==== core/calib_datapath.sv ====
// measurement correction datapath with apb calibration registers
`timescale 1ns/100ps
module calib_datapath #(
   parameter int COEF_W = 8
) (
   input  wire logic                          clk,
   input  wire logic                          nrst,
   input  wire logic [11:0]                   paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          measStart,
   input  wire calib_pkg::kind_t              measKind,
   input  wire logic [3:0]                    measChan,
   input  wire logic [31:0]                   measRaw,
   output logic                               resValid,
   output logic      [31:0]                   resData,
   input  wire logic [17:0][15:0]             factoryGain,
   input  wire logic [31:0]                   adcOffsetTrim,
   input  wire logic [COEF_W-1:0]             ovTrim,
   input  wire logic [COEF_W-1:0]             uvTrim,
   input  wire logic                          thrCmpTrip,
   output logic      [COEF_W-1:0]             thrTrial,
   output logic                               thrCalUv,
   output logic                               thrSearching,
   output logic      [COEF_W-1:0]             ovThreshold,
   output logic      [COEF_W-1:0]             uvThreshold
);
   localparam int NG = calib_pkg::NGAIN;
   localparam int NT = calib_pkg::NTEMP;
   localparam int GW = calib_pkg::GAIN_W;
   localparam int OW = calib_pkg::OFS_W;
   localparam int SCW = $clog2(calib_pkg::SETTLE_CYC + 1);
   localparam logic [SCW-1:0] SETTLE_LOAD = SCW'(calib_pkg::SETTLE_CYC);
   localparam logic [11:0] GAIN_END = calib_pkg::GAIN_BASE + 12'(4 * NG);
   localparam logic [11:0] TEMP_END = calib_pkg::TEMP_BASE + 12'(4 * NT);

   if (COEF_W < 2 || COEF_W > 16) begin : g_chk
      $error("calib_datapath: COEF_W must be 2 to 16");
   end

   // bus strobes
   logic setup;
   logic wrEn;
   logic calWr;
   logic gainHit;
   logic tempHit;
   logic [4:0] gainIdx;
   logic [4:0] tempIdx;

   // software state
   logic                   unrestricted_access_mode_q;
   logic                   cfgUpd_q;
   logic [NG-1:0][GW-1:0]  gainCal_q;
   logic [NG-1:0]          gainSet_q;
   logic [NG-1:0][GW-1:0]  effGain;
   logic [NT-1:0][OW-1:0]  tempOfs_q;
   logic [OW-1:0]          cellOfs_q;
   logic [OW-1:0]          divOfs_q;
   logic [31:0]            ccOfs_q;
   logic [7:0]             ccSamp_q;
   logic [31:0]            curGain_q;
   logic [31:0]            capGain_q;
   logic [31:0]            capProd;
   logic [COEF_W-1:0]      ovOvr_q;
   logic [COEF_W-1:0]      uvOvr_q;
   logic [31:0]            rdMux;
   logic                   rdErr;
   logic [31:0]            prdata_q;
   logic                   pslverr_q;

   // threshold search
   calib_pkg::cal_state_t  state_q;
   logic [COEF_W-1:0]      trial_q;
   logic [$clog2(COEF_W)-1:0] bitPos_q;
   logic [SCW-1:0]         settle_q;
   logic                   calUv_q;
   logic                   calDone_q;
   logic [COEF_W-1:0]      resp_q;
   logic                   calStart;
   logic                   calLast;
   logic [COEF_W-1:0]      trialKept;

   // result path
   logic [31:0]            resData_q;
   logic                   resValid_q;

   assign setup   = psel & ~penable;
   assign wrEn    = psel & penable & pwrite;
   assign calWr   = wrEn & cfgUpd_q;
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;
   assign gainHit = (paddr >= calib_pkg::GAIN_BASE) && (paddr < GAIN_END) && (paddr[1:0] == 2'h0);
   assign tempHit = (paddr >= calib_pkg::TEMP_BASE) && (paddr < TEMP_END) && (paddr[1:0] == 2'h0);
   assign gainIdx = 5'((paddr - calib_pkg::GAIN_BASE) >> 2);
   assign tempIdx = 5'((paddr - calib_pkg::TEMP_BASE) >> 2);

   // access modes; update mode only with full access already held or set in the same write
   always_ff @(posedge clk) begin
      if (!nrst) begin
         unrestricted_access_mode_q <= 1'b0;
         cfgUpd_q     <= 1'b0;
      end else if (wrEn && paddr == calib_pkg::CTRL_ADDR) begin
         unrestricted_access_mode_q <= pwdata[calib_pkg::CTRL_FULL_BIT];
         cfgUpd_q     <= pwdata[calib_pkg::CTRL_CFG_BIT]
                         & (unrestricted_access_mode_q | pwdata[calib_pkg::CTRL_FULL_BIT]);
      end
   end

   // calibration gains, one per cell plus stack, pack, load detect, general input
   always_ff @(posedge clk) begin
      if (!nrst) begin
         gainCal_q <= '0;
         gainSet_q <= '0;
      end else if (calWr && gainHit) begin
         gainCal_q[gainIdx] <= pwdata[GW-1:0];
         gainSet_q[gainIdx] <= 1'b1;
      end
   end

   // gain in operation: written, else factory trim, else nominal
   always_comb begin
      for (int i = 0; i < NG; i++) begin
         if (gainSet_q[i]) begin
            effGain[i] = gainCal_q[i];
         end else if (factoryGain[i] != '0) begin
            effGain[i] = factoryGain[i];
         end else if (i < calib_pkg::NCELL) begin
            effGain[i] = calib_pkg::NOM_CELL_GAIN;
         end else if (i == calib_pkg::GAIN_ADC) begin
            effGain[i] = calib_pkg::NOM_ADC_GAIN;
         end else begin
            effGain[i] = calib_pkg::NOM_DIV_GAIN;
         end
      end
   end

   // offsets and current settings
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cellOfs_q <= '0;
         divOfs_q  <= '0;
         ccOfs_q   <= '0;
         ccSamp_q  <= calib_pkg::CC_SAMP_RST;
         curGain_q <= calib_pkg::CUR_GAIN_RST;
         tempOfs_q <= '0;
      end else if (calWr) begin
         if (paddr == calib_pkg::CELLO_ADDR) cellOfs_q <= pwdata[OW-1:0];
         if (paddr == calib_pkg::DIVO_ADDR) divOfs_q <= pwdata[OW-1:0];
         if (paddr == calib_pkg::CCO_ADDR) ccOfs_q <= pwdata;
         if (paddr == calib_pkg::CCS_ADDR) ccSamp_q <= pwdata[calib_pkg::SAMP_W-1:0];
         if (paddr == calib_pkg::CCG_ADDR) curGain_q <= pwdata;
         if (tempHit) tempOfs_q[tempIdx] <= pwdata[OW-1:0];
      end
   end

   fp_mul #(
      .EXP_W (8),
      .MAN_W (23)
   ) u_capmul (
      .a (curGain_q),
      .b (calib_pkg::CAP_K),
      .p (capProd)
   );

   // capacity gain follows the current gain
   always_ff @(posedge clk) begin
      if (!nrst) begin
         capGain_q <= '0;
      end else begin
         capGain_q <= capProd;
      end
   end

   // threshold coefficient search, msb first
   assign calStart  = calWr && paddr == calib_pkg::CMD_ADDR && state_q == calib_pkg::CAL_IDLE
                      && (pwdata[15:0] == calib_pkg::CMD_OV_CAL
                          || pwdata[15:0] == calib_pkg::CMD_UV_CAL);
   assign calLast   = state_q == calib_pkg::CAL_SEARCH && settle_q == '0 && bitPos_q == '0;
   assign trialKept = thrCmpTrip ? trial_q : (trial_q & ~(COEF_W'(1) << bitPos_q));

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q   <= calib_pkg::CAL_IDLE;
         trial_q   <= '0;
         bitPos_q  <= '0;
         settle_q  <= '0;
         calUv_q   <= 1'b0;
         calDone_q <= 1'b0;
         resp_q    <= '0;
      end else begin
         case (state_q)
            calib_pkg::CAL_IDLE: begin
               if (calStart) begin
                  state_q   <= calib_pkg::CAL_SEARCH;
                  calUv_q   <= pwdata[15:0] == calib_pkg::CMD_UV_CAL;
                  trial_q   <= COEF_W'(1) << (COEF_W - 1);
                  bitPos_q  <= ($clog2(COEF_W))'(COEF_W - 1);
                  settle_q  <= SETTLE_LOAD;
                  calDone_q <= 1'b0;
               end
            end
            calib_pkg::CAL_SEARCH: begin
               if (settle_q != '0) begin
                  settle_q <= settle_q - SCW'(1);
               end else if (calLast) begin
                  state_q   <= calib_pkg::CAL_IDLE;
                  trial_q   <= trialKept;
                  resp_q    <= trialKept;
                  calDone_q <= 1'b1;
               end else begin
                  trial_q  <= trialKept | (COEF_W'(1) << (bitPos_q - 1'b1));
                  bitPos_q <= bitPos_q - 1'b1;
                  settle_q <= SETTLE_LOAD;
               end
            end
            default: state_q <= calib_pkg::CAL_IDLE;
         endcase
      end
   end

   // threshold overrides; search result wins over a software write
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ovOvr_q <= '0;
         uvOvr_q <= '0;
      end else if (calLast) begin
         if (calUv_q) uvOvr_q <= trialKept;
         else ovOvr_q <= trialKept;
      end else if (calWr) begin
         if (paddr == calib_pkg::OVO_ADDR) ovOvr_q <= pwdata[COEF_W-1:0];
         if (paddr == calib_pkg::UVO_ADDR) uvOvr_q <= pwdata[COEF_W-1:0];
      end
   end

   assign ovThreshold  = (ovOvr_q != '0) ? ovOvr_q : ovTrim;
   assign uvThreshold  = (uvOvr_q != '0) ? uvOvr_q : uvTrim;
   assign thrTrial     = trial_q;
   assign thrCalUv     = calUv_q;
   assign thrSearching = state_q == calib_pkg::CAL_SEARCH;

   // read mux
   always_comb begin
      rdMux = '0;
      rdErr = 1'b0;
      if (gainHit) begin
         if (cfgUpd_q) begin
            rdMux[GW-1:0] = gainSet_q[gainIdx] ? gainCal_q[gainIdx] : '0;
         end else if (unrestricted_access_mode_q) begin
            rdMux[GW-1:0] = effGain[gainIdx];
         end
      end else if (tempHit) begin
         rdMux[OW-1:0] = tempOfs_q[tempIdx];
      end else begin
         case (paddr)
            calib_pkg::CTRL_ADDR: begin
               rdMux[calib_pkg::CTRL_FULL_BIT] = unrestricted_access_mode_q;
               rdMux[calib_pkg::CTRL_CFG_BIT]  = cfgUpd_q;
            end
            calib_pkg::STAT_ADDR: begin
               rdMux[calib_pkg::STAT_BUSY_BIT] = thrSearching;
               rdMux[calib_pkg::STAT_DONE_BIT] = calDone_q;
            end
            calib_pkg::CMD_ADDR:   rdMux = '0;
            calib_pkg::RESP_ADDR:  rdMux[COEF_W-1:0] = resp_q;
            calib_pkg::CELLO_ADDR: rdMux[OW-1:0] = cellOfs_q;
            calib_pkg::DIVO_ADDR:  rdMux[OW-1:0] = divOfs_q;
            calib_pkg::CCO_ADDR:   rdMux = ccOfs_q;
            calib_pkg::CCS_ADDR:   rdMux[calib_pkg::SAMP_W-1:0] = ccSamp_q;
            calib_pkg::CCG_ADDR:   rdMux = curGain_q;
            calib_pkg::CAPG_ADDR:  rdMux = capGain_q;
            calib_pkg::OVO_ADDR:   rdMux[COEF_W-1:0] = ovOvr_q;
            calib_pkg::UVO_ADDR:   rdMux[COEF_W-1:0] = uvOvr_q;
            default:               rdErr = 1'b1;
         endcase
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= pwrite ? 32'h0 : rdMux;
         pslverr_q <= rdErr;
      end
   end

   // correction arithmetic, signed, gains and sample count taken as unsigned
   logic [GW-1:0]              selGain;
   logic signed [31:0]         trimmed;
   logic signed [GW+calib_pkg::CNT_W:0] vProd;
   logic signed [31:0]         vScaled;
   logic signed [31:0]         vOfs;
   logic [7:0]                 samp;
   logic signed [31:0]         ccAvg;
   logic signed [31:0]         ccCorr;
   logic [7:0]                 cExp;
   logic signed [63:0]         mant;
   logic signed [63:0]         cProd;
   logic signed [63:0]         cRes;
   logic signed [31:0]         tOfs;
   logic [31:0]                resNext;

   always_comb begin
      case (measKind)
         calib_pkg::K_STACK: selGain = effGain[calib_pkg::GAIN_STACK];
         calib_pkg::K_PACK:  selGain = effGain[calib_pkg::GAIN_PACK];
         calib_pkg::K_LOAD:  selGain = effGain[calib_pkg::GAIN_LOAD];
         calib_pkg::K_GPIN:  selGain = effGain[calib_pkg::GAIN_ADC];
         default: selGain = (measChan < 4'(calib_pkg::NCELL)) ? effGain[measChan] : '0;
      endcase
      trimmed = $signed(measRaw) - $signed(adcOffsetTrim);
      vProd   = $signed({1'b0, selGain}) * $signed(trimmed[calib_pkg::CNT_W-1:0]);
      vScaled = 32'(vProd >>> calib_pkg::FRAC_SH);
      case (measKind)
         calib_pkg::K_CELL: vOfs = 32'($signed(cellOfs_q));
         calib_pkg::K_STACK,
         calib_pkg::K_PACK,
         calib_pkg::K_LOAD: vOfs = 32'($signed(divOfs_q));
         default:           vOfs = '0;
      endcase

      samp   = (ccSamp_q == '0) ? 8'h01 : ccSamp_q;
      ccAvg  = $signed(ccOfs_q) / $signed({24'h0, samp});
      ccCorr = $signed(measRaw) - ccAvg;
      cExp   = curGain_q[30:23];
      mant   = (cExp == '0) ? 64'sh0 : $signed({40'h0, 1'b1, curGain_q[22:0]});
      cProd  = 64'(ccCorr) * mant;
      if (cExp >= calib_pkg::FP_POINT) begin
         cRes = cProd <<< (cExp - calib_pkg::FP_POINT);
      end else begin
         cRes = cProd >>> (calib_pkg::FP_POINT - cExp);
      end
      if (curGain_q[31]) begin
         cRes = -cRes;
      end

      tOfs = (measChan < 4'(NT)) ? 32'($signed(tempOfs_q[measChan])) : 32'sh0;

      case (measKind)
         calib_pkg::K_CURR: resNext = cRes[31:0];
         calib_pkg::K_TEMP: resNext = $signed(measRaw) + tOfs;
         calib_pkg::K_CELL: resNext = (measChan < 4'(calib_pkg::NCELL)) ? vScaled - vOfs : '0;
         default:           resNext = vScaled - vOfs;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         resValid_q <= 1'b0;
         resData_q  <= '0;
      end else begin
         resValid_q <= measStart;
         if (measStart) resData_q <= resNext;
      end
   end

   assign resValid = resValid_q;
   assign resData  = resData_q;
endmodule : calib_datapath

// ==== testbench/threshold_comparator_model.sv ====
// behavioural threshold comparator standing beside the calibration search
`timescale 1ns/100ps
module threshold_comparator_model (
   input  wire logic       clk,
   input  wire logic       thrSearching,
   input  wire logic [7:0] thrTrial,
   input  wire logic [7:0] target,
   output logic            thrCmpTrip
);
   initial thrCmpTrip = 1'b0;
   // applied voltage sits at target; outside a search the output is meaningless
   always @(posedge clk) begin
      thrCmpTrip <= thrSearching ? (target >= thrTrial) : ~thrCmpTrip;
   end
endmodule : threshold_comparator_model

// ==== testbench/calib_datapath_assertions.sv ====
// port assertions for the calibration datapath
`timescale 1ns/100ps
module calib_datapath_assertions #(
   parameter int COEF_W = 8
) (
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              measStart,
   input wire calib_pkg::kind_t  measKind,
   input wire logic [3:0]        measChan,
   input wire logic [31:0]       measRaw,
   input wire logic [31:0]       adcOffsetTrim,
   input wire logic              resValid,
   input wire logic [31:0]       resData,
   input wire logic [COEF_W-1:0] ovTrim,
   input wire logic [COEF_W-1:0] uvTrim,
   input wire logic [COEF_W-1:0] thrTrial,
   input wire logic              thrCalUv,
   input wire logic              thrSearching,
   input wire logic [COEF_W-1:0] ovThreshold,
   input wire logic [COEF_W-1:0] uvThreshold
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_res_latency: assert property (measStart |=> resValid)
      else $error("result pulse missing");
   a_res_single: assert property (!measStart |=> !resValid)
      else $error("result pulse without request");
   a_gpin_zero: assert property (measStart && measKind == calib_pkg::K_GPIN
      && measRaw == adcOffsetTrim |=> resData == 32'h0)
      else $error("general input result not zero");
   a_temp_plain: assert property (measStart && measKind == calib_pkg::K_TEMP
      && measChan > 4'h9 |=> resData == $past(measRaw))
      else $error("unknown temperature source altered");
   a_search_min: assert property ($rose(thrSearching) |-> thrSearching[*8])
      else $error("search too short");
   a_search_max: assert property ($rose(thrSearching) |-> ##[1:1000] !thrSearching)
      else $error("search never ends");
   a_trial_hold: assert property (thrSearching && $changed(thrTrial)
      |=> $stable(thrTrial)[*8])
      else $error("trial not held to settle");
   a_kind_stable: assert property (thrSearching && $past(thrSearching) |-> $stable(thrCalUv))
      else $error("search kind changed");
   a_ov_store: assert property ($fell(thrSearching) && !thrCalUv
      |=> ovThreshold == ((thrTrial != '0) ? thrTrial : ovTrim))
      else $error("overvoltage result not applied");
   a_uv_store: assert property ($fell(thrSearching) && thrCalUv
      |=> uvThreshold == ((thrTrial != '0) ? thrTrial : uvTrim))
      else $error("undervoltage result not applied");
endmodule : calib_datapath_assertions
bind calib_datapath calib_datapath_assertions #(.COEF_W(COEF_W)) chk (.clk, .nrst,
   .measStart, .measKind, .measChan, .measRaw, .adcOffsetTrim, .resValid, .resData,
   .ovTrim, .uvTrim, .thrTrial, .thrCalUv, .thrSearching, .ovThreshold, .uvThreshold);

// ==== testbench/measurement_calibration_datapath_test.sv ====
// self-checking bench for the calibration datapath
`timescale 1ns/100ps
module measurement_calibration_datapath_test;
   logic             clk = 1'b0;
   logic             nrst = 1'b0;
   logic [11:0]      paddr = 12'h000;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [31:0]      pwdata = 32'h0;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             measStart = 1'b0;
   calib_pkg::kind_t measKind = calib_pkg::K_CELL;
   logic [3:0]       measChan = 4'h0;
   logic [31:0]      measRaw = 32'h0;
   logic             resValid;
   logic [31:0]      resData;
   logic [17:0][15:0] factoryGain;
   logic [31:0]      adcOffsetTrim = 32'h100;
   logic [7:0]       ovTrim = 8'h11;
   logic [7:0]       uvTrim = 8'h22;
   logic [7:0]       target = 8'h00;
   logic             thrCmpTrip;
   logic [7:0]       thrTrial;
   logic             thrCalUv;
   logic             thrSearching;
   logic [7:0]       ovThreshold;
   logic [7:0]       uvThreshold;
   logic [31:0]      rd;
   logic             err;
   int               failures = 0;
   int               total_checks = 0;

   calib_datapath DUT (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .measStart, .measKind, .measChan, .measRaw, .resValid, .resData,
      .factoryGain, .adcOffsetTrim, .ovTrim, .uvTrim, .thrCmpTrip, .thrTrial, .thrCalUv,
      .thrSearching, .ovThreshold, .uvThreshold);
   threshold_comparator_model model (.clk, .thrSearching, .thrTrial, .target, .thrCmpTrip);

   initial forever #50 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rchk

   task automatic meas(input calib_pkg::kind_t k, input logic [3:0] c,
                       input logic [31:0] r, input logic [31:0] e);
      @(posedge clk);
      measStart <= 1'b1;
      measKind  <= k;
      measChan  <= c;
      measRaw   <= r;
      @(posedge clk);
      measStart <= 1'b0;
      @(negedge clk);
      chk({31'h0, resValid}, 32'h1);
      chk(resData, e);
   endtask : meas

   task automatic cal(input logic [31:0] code, input logic [7:0] t);
      target <= t;
      apb(1'b1, calib_pkg::CMD_ADDR, code);
      rd = 32'h0;
      for (int n = 0; n < 400 && rd[1] !== 1'b1; n++) begin
         apb(1'b0, calib_pkg::STAT_ADDR, 32'h0);
      end
      chk({31'h0, rd[1]}, 32'h1);
   endtask : cal

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   initial begin
      #800000;
      failures++;
      end_sim();
   end

   initial begin
      for (int i = 0; i < 18; i++) begin
         factoryGain[i] = 16'h2f00 + 16'(4 * i);
      end
      factoryGain[5]  = 16'h0000;
      factoryGain[17] = 16'h0000;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rchk(calib_pkg::CCS_ADDR, 32'h1);
      rchk(calib_pkg::CCG_ADDR, 32'h3f800000);
      rchk(calib_pkg::CAPG_ADDR, 32'h4891a2b4);
      apb(1'b0, 12'h3fc, 32'h0);
      chk({31'h0, err}, 32'h1);
      rchk(calib_pkg::GAIN_BASE + 12'h00c, 32'h0);
      $display("test reset done");
      apb(1'b1, calib_pkg::CTRL_ADDR, 32'h1);
      rchk(calib_pkg::GAIN_BASE + 12'h00c, 32'h2f0c);
      apb(1'b1, calib_pkg::CTRL_ADDR, 32'h3);
      rchk(calib_pkg::GAIN_BASE + 12'h00c, 32'h0);
      apb(1'b1, calib_pkg::GAIN_BASE + 12'h00c, 32'h3000);
      rchk(calib_pkg::GAIN_BASE + 12'h00c, 32'h3000);
      apb(1'b1, calib_pkg::CELLO_ADDR, 32'h10);
      apb(1'b1, calib_pkg::DIVO_ADDR, 32'h20);
      meas(calib_pkg::K_CELL, 4'h3, 32'h4100, 32'hbf0);
      meas(calib_pkg::K_CELL, 4'h3, 32'hffffc100, 32'hfffff3f0);
      meas(calib_pkg::K_CELL, 4'h4, 32'h4100, 32'hbb4);
      meas(calib_pkg::K_CELL, 4'h5, 32'h4100, 32'hbc6);
      meas(calib_pkg::K_STACK, 4'h0, 32'h4100, 32'hbae);
      meas(calib_pkg::K_PACK, 4'h0, 32'h4100, 32'hbaf);
      meas(calib_pkg::K_LOAD, 4'h0, 32'h4100, 32'hbb0);
      meas(calib_pkg::K_GPIN, 4'h0, 32'h4100, 32'h3f2);
      meas(calib_pkg::K_CELL, 4'he, 32'h4100, 32'h0);
      apb(1'b1, calib_pkg::CTRL_ADDR, 32'h1);
      rchk(calib_pkg::GAIN_BASE + 12'h00c, 32'h3000);
      rchk(calib_pkg::GAIN_BASE + 12'h010, 32'h2f10);
      $display("test voltage done");
      apb(1'b1, calib_pkg::CTRL_ADDR, 32'h3);
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, calib_pkg::TEMP_BASE + 12'(4 * i), {16'h0, 16'(i - 3)});
         meas(calib_pkg::K_TEMP, 4'(i), 32'd2980, 32'(2977 + i));
      end
      meas(calib_pkg::K_TEMP, 4'hc, 32'd2980, 32'd2980);
      $display("test temperature done");
      apb(1'b1, calib_pkg::CCO_ADDR, 32'd100);
      apb(1'b1, calib_pkg::CCS_ADDR, 32'd4);
      apb(1'b1, calib_pkg::CCG_ADDR, 32'h40000000);
      rchk(calib_pkg::CAPG_ADDR, 32'h4911a2b4);
      meas(calib_pkg::K_CURR, 4'h0, 32'd1025, 32'd2000);
      meas(calib_pkg::K_CURR, 4'h0, -32'sd975, -32'sd2000);
      $display("test current done");
      chk({24'h0, ovThreshold}, {24'h0, ovTrim});
      cal(32'h1, 8'h5a);
      rchk(calib_pkg::RESP_ADDR, 32'h5a);
      rchk(calib_pkg::OVO_ADDR, 32'h5a);
      chk({24'h0, ovThreshold}, 32'h5a);
      chk({24'h0, uvThreshold}, {24'h0, uvTrim});
      cal(32'h2, 8'h33);
      rchk(calib_pkg::RESP_ADDR, 32'h33);
      rchk(calib_pkg::UVO_ADDR, 32'h33);
      chk({24'h0, uvThreshold}, 32'h33);
      apb(1'b1, calib_pkg::OVO_ADDR, 32'h0);
      @(negedge clk);
      chk({24'h0, ovThreshold}, {24'h0, ovTrim});
      $display("test threshold done");
      end_sim();
   end
endmodule : measurement_calibration_datapath_test
